//--- include/lpwake_pkg.sv
/*
 * Constants for the low-power current wake-up register bank: window bases,
 * register offsets, field positions, reset values and datapath widths.
 * Assumes a 16-bit host register bus with a 16-bit global address.
 */
package lpwake_pkg;

  // ****************************************
  // Address windows and offsets
  // ****************************************
  localparam logic [7:0]  BASE_BLOCKING_HI = 8'h0E;  // Window 0x0E00
  localparam logic [7:0]  BASE_NONBLOCK_HI = 8'h0F;  // Window 0x0F00
  localparam logic [7:0]  OFS_PER          = 8'h72;
  localparam logic [7:0]  OFS_FCTL         = 8'h74;
  localparam logic [7:0]  OFS_CLV          = 8'h76;
  localparam logic [7:0]  OFS_AHLV_HI      = 8'h78;  // Bits 30-16
  localparam logic [7:0]  OFS_AHLV_LO      = 8'h7A;  // Bits 15-0

  // ****************************************
  // Widths
  // ****************************************
  localparam int          BUS_W   = 16;
  localparam int          ADDR_W  = 16;
  localparam int          CUR_W   = 24;
  localparam int          AH_W    = 32;
  localparam int          AHLV_W  = 31;
  localparam int          TRIG_W  = 16;
  localparam int          LVL_W   = 8;
  localparam int          COEF_W  = 3;
  localparam int          IIR_FRAC = 8;

  // ****************************************
  // Reset values
  // ****************************************
  localparam logic [7:0]        RST_PER  = 8'h00;
  localparam logic [15:0]       RST_FCTL = 16'h000E;
  localparam logic [7:0]        RST_CLV  = 8'h00;
  localparam logic [AHLV_W-1:0] RST_AHLV = 31'h00000000;

  // ****************************************
  // Control field layout and coefficient coding
  // ****************************************
  localparam int          CMASK_MSB    = 11;
  localparam int          CMASK_LSB    = 9;
  localparam int          COEF_MSB     = 3;
  localparam int          COEF_LSB     = 1;
  localparam logic [2:0]  CMASK_ENABLE = 3'h7;
  localparam logic [2:0]  IIR_SHIFT_BASE = 3'h3;   // Code 000 gives 1/8
  localparam logic [2:0]  IIR_CODE_MAX   = 3'h4;   // Above this: bypass
  localparam int          CLV_LSB      = 16;       // Level compares bits 23-16

  // Atomic read holding state
  typedef enum logic [2:0] {
    LOCK_NONE    = 3'b001,
    LOCK_LO_HELD = 3'b010,
    LOCK_HI_HELD = 3'b100
  } hold_state_t;

endpackage : lpwake_pkg

//--- rtl/iir_lowpass.sv
/*
 * First-order IIR low-pass on the current samples, y += alpha*(x - y).
 * Assumes samples arrive as one-cycle valid pulses on mclk.
 */
`timescale 1ns/1ps
module iir_lowpass (
  input  wire logic                                mclk,
  input  wire logic                                rstn,
  input  wire logic [lpwake_pkg::COEF_W-1:0]       coef_select,
  input  wire logic                                sample_valid,
  input  wire logic signed [lpwake_pkg::CUR_W-1:0] sample_in,
  output logic signed [lpwake_pkg::CUR_W-1:0]      filt_out,
  output logic                                     filt_valid
);
  import lpwake_pkg::*;

  localparam int ACC_W = CUR_W + IIR_FRAC;

  logic signed [ACC_W-1:0] acc_r;
  logic signed [ACC_W-1:0] acc_nxt;
  logic signed [ACC_W-1:0] x_ext;
  logic signed [ACC_W:0]   diff;
  logic signed [ACC_W:0]   step;
  logic [2:0]              shift;
  logic                    bypass;

  // Alpha from code: shift 3..7, or pass-through
  assign bypass  = (coef_select > IIR_CODE_MAX);              // see R6
  assign shift   = IIR_SHIFT_BASE + coef_select;              // see R5
  assign x_ext   = {sample_in, {IIR_FRAC{1'b0}}};
  assign diff    = {x_ext[ACC_W-1], x_ext} - {acc_r[ACC_W-1], acc_r};
  assign step    = diff >>> shift;
  assign acc_nxt = bypass ? x_ext : acc_r + step[ACC_W-1:0];  // see R6

  // Accumulator and output on each sample
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      acc_r      <= '0;
      filt_out   <= '0;
      filt_valid <= 1'b0;
    end else begin
      filt_valid <= sample_valid;
      if (sample_valid) begin
        acc_r    <= acc_nxt;
        filt_out <= acc_nxt[ACC_W-1:IIR_FRAC];
      end
    end
  end

endmodule : iir_lowpass

//--- rtl/lowpower_current_wakeup_regs.sv
/*
 * Register bank for the low-power current and amp-hour wake-up settings,
 * with the IIR filter control, low-power trigger counter and wake requests.
 * Assumes the host register bus, low-power tick, samples and amp-hour count
 * all come from logic on mclk.
 */
`timescale 1ns/1ps

// Function
// R1: Registers decode at offset plus 0x0E00 (blocking) and 0x0F00 (non-blocking).
// R2: Filtering period, 8-bit read/write at 0x72, reset zero.
// R3: Software uses only 16-bit transfers on the filter control register.
// R4: Coefficient bits 3-1 change only when mask bits 11-9 are 111.
// R5: Codes 000..100 give alpha 1/8, 1/16, 1/32, 1/64, 1/128.
// R6: Codes 101, 110, 111 bypass the filter, alpha one.
// R7: Current level, 8-bit read/write at 0x76, reset zero.
// R8: Amp-hour threshold, unsigned 31 bits at 0x78-0x7B, read/write, reset zero.
// R9: Reading one threshold half buffers the other for a consistent pair.
// R10: Reading the buffered half returns the buffer and releases it.
// R11: In low power, trigger counter equal to period starts an acquisition.
// R12: Current wake request only after condition persists the filtering period.
// R13: Filter control register and unused bits read as zero.
module lowpower_current_wakeup_regs (
  input  wire logic                                 mclk,
  input  wire logic                                 rstn,
  input  wire logic [lpwake_pkg::ADDR_W-1:0]        bus_addr,
  input  wire logic                                 bus_rd,
  input  wire logic                                 bus_wr,
  input  wire logic                                 bus_size16,
  input  wire logic [lpwake_pkg::BUS_W-1:0]         bus_wdata,
  output logic      [lpwake_pkg::BUS_W-1:0]         bus_rdata,
  output logic                                      bus_ack,
  input  wire logic                                 lowpower_mode,
  input  wire logic                                 lp_tick,
  input  wire logic [lpwake_pkg::TRIG_W-1:0]        lowpower_trigger_period,
  input  wire logic                                 sample_valid,
  input  wire logic signed [lpwake_pkg::CUR_W-1:0]  sample_current,
  input  wire logic signed [lpwake_pkg::AH_W-1:0]   amp_hour_count,
  output logic                                      acq_start,
  output logic signed [lpwake_pkg::CUR_W-1:0]       filt_current,
  output logic                                      filt_valid,
  output logic                                      current_wake_req,
  output logic                                      amp_hour_wake_req
);
  import lpwake_pkg::*;

  // ****************************************
  // Declarations
  // ****************************************
  logic [7:0]          wake_filter_period_r;
  logic [7:0]          current_wake_level_r;
  logic [AHLV_W-1:0]   amp_hour_wake_level_r;
  logic [COEF_W-1:0]   iir_coef_select_r;
  logic [BUS_W-1:0]    hold_r;
  logic [BUS_W-1:0]    hold_nxt;
  hold_state_t         hold_state_r;
  hold_state_t         hold_state_nxt;
  logic [TRIG_W-1:0]   trig_count_r;
  logic [BUS_W-1:0]    rdata_nxt;

  wire                 in_window;
  wire [7:0]           ofs;
  wire [7:0]           ofs_word;
  wire                 odd_byte;
  wire                 bad_align;
  wire                 hit_per;
  wire                 hit_fctl;
  wire                 hit_clv;
  wire                 hit_ah_hi;
  wire                 hit_ah_lo;
  wire                 any_access;
  wire                 rd16;
  wire                 hi_lane_en;
  wire                 lo_lane_en;
  wire [7:0]           hi_lane_data;
  wire [7:0]           lo_lane_data;
  wire [BUS_W-1:0]     ah_hi_live;
  wire [BUS_W-1:0]     ah_lo_live;
  wire [BUS_W-1:0]     live_word;
  wire [BUS_W-1:0]     read_word;
  wire [7:0]           read_byte;
  wire [COEF_W-1:0]    coef_mask;
  wire                 coef_write;
  wire                 trig_hit;
  wire [CUR_W-1:0]     filt_mag;
  wire                 current_cond;
  wire [AH_W-1:0]      ah_mag;
  wire                 ah_cond;

  // ****************************************
  // Address decode
  // ****************************************

  // Both windows map the same registers
  assign in_window  = (bus_addr[15:8] == BASE_BLOCKING_HI) ||
                      (bus_addr[15:8] == BASE_NONBLOCK_HI);  // see R1
  assign ofs        = bus_addr[7:0];
  assign ofs_word   = {ofs[7:1], 1'b0};
  assign odd_byte   = ofs[0];
  assign bad_align  = bus_size16 && odd_byte;   // Odd word address: unmapped
  assign hit_per    = in_window && !bad_align && (ofs_word == OFS_PER);
  assign hit_fctl   = in_window && !bad_align && (ofs_word == OFS_FCTL);
  assign hit_clv    = in_window && !bad_align && (ofs_word == OFS_CLV);
  assign hit_ah_hi  = in_window && !bad_align && (ofs_word == OFS_AHLV_HI);
  assign hit_ah_lo  = in_window && !bad_align && (ofs_word == OFS_AHLV_LO);
  assign any_access = bus_rd || bus_wr;
  assign rd16       = bus_rd && bus_size16;

  // Byte lanes, big-endian: even offset is the high byte
  assign hi_lane_en   = bus_size16 || !odd_byte;
  assign lo_lane_en   = bus_size16 || odd_byte;
  assign hi_lane_data = bus_size16 ? bus_wdata[15:8] : bus_wdata[7:0];
  assign lo_lane_data = bus_wdata[7:0];

  // ****************************************
  // Read path
  // ****************************************

  // Live words; bit 15 of the high half is unused
  assign ah_hi_live = {1'b0, amp_hour_wake_level_r[AHLV_W-1:BUS_W]};  // see R13
  assign ah_lo_live = amp_hour_wake_level_r[BUS_W-1:0];

  // Live word at the addressed offset, control register reads zero
  assign live_word = hit_per   ? {wake_filter_period_r, 8'h00} :
                     hit_clv   ? {current_wake_level_r, 8'h00} :
                     hit_ah_hi ? ah_hi_live :
                     hit_ah_lo ? ah_lo_live :
                     16'h0000;                                          // see R13

  // Buffered half answers a 16-bit read of the held word
  assign read_word = (rd16 && hit_ah_lo && hold_state_r == LOCK_LO_HELD) ? hold_r :
                     (rd16 && hit_ah_hi && hold_state_r == LOCK_HI_HELD) ? hold_r :
                     live_word;                                         // see R10
  assign read_byte = odd_byte ? live_word[7:0] : live_word[15:8];
  assign rdata_nxt = !bus_rd    ? bus_rdata :
                     bus_size16 ? read_word : {8'h00, read_byte};

  // Bus answer one cycle after each strobe, mapped or not
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      bus_ack   <= 1'b0;
      bus_rdata <= 16'h0000;
    end else begin
      bus_ack   <= any_access;
      bus_rdata <= rdata_nxt;
    end
  end

  // ****************************************
  // Atomic threshold read buffer
  // ****************************************

  // First 16-bit half read captures the other half
  always_comb begin
    hold_state_nxt = hold_state_r;
    hold_nxt       = hold_r;
    unique case (hold_state_r)
      LOCK_NONE: begin
        if (rd16 && hit_ah_hi) begin
          hold_nxt       = ah_lo_live;                                  // see R9
          hold_state_nxt = LOCK_LO_HELD;
        end else if (rd16 && hit_ah_lo) begin
          hold_nxt       = ah_hi_live;                                  // see R9
          hold_state_nxt = LOCK_HI_HELD;
        end
      end
      LOCK_LO_HELD: begin
        if (rd16 && hit_ah_lo) begin
          hold_state_nxt = LOCK_NONE;                                   // see R10
        end else if (rd16 && hit_ah_hi) begin
          hold_nxt       = ah_lo_live;
        end
      end
      LOCK_HI_HELD: begin
        if (rd16 && hit_ah_hi) begin
          hold_state_nxt = LOCK_NONE;                                   // see R10
        end else if (rd16 && hit_ah_lo) begin
          hold_nxt       = ah_hi_live;
        end
      end
      default: begin
        hold_state_nxt = LOCK_NONE;
      end
    endcase
  end

  // Buffer state registers
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      hold_state_r <= LOCK_NONE;
      hold_r       <= 16'h0000;
    end else begin
      hold_state_r <= hold_state_nxt;
      hold_r       <= hold_nxt;
    end
  end

  // ****************************************
  // Writable registers
  // ****************************************

  // Filtering period and current level
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      wake_filter_period_r <= RST_PER;
      current_wake_level_r <= RST_CLV;
    end else begin
      if (bus_wr && hit_per && hi_lane_en) begin
        wake_filter_period_r <= hi_lane_data;                           // see R2
      end
      if (bus_wr && hit_clv && hi_lane_en) begin
        current_wake_level_r <= hi_lane_data;                           // see R7
      end
    end
  end

  // Amp-hour threshold, per byte lane; bit 31 is not stored
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      amp_hour_wake_level_r <= RST_AHLV;
    end else if (bus_wr) begin
      if (hit_ah_hi && hi_lane_en) begin
        amp_hour_wake_level_r[30:24] <= hi_lane_data[6:0];              // see R8
      end
      if (hit_ah_hi && lo_lane_en) begin
        amp_hour_wake_level_r[23:16] <= lo_lane_data;                   // see R8
      end
      if (hit_ah_lo && hi_lane_en) begin
        amp_hour_wake_level_r[15:8] <= hi_lane_data;                    // see R8
      end
      if (hit_ah_lo && lo_lane_en) begin
        amp_hour_wake_level_r[7:0] <= lo_lane_data;                     // see R8
      end
    end
  end

  // Masked coefficient update, 16-bit writes only
  assign coef_mask  = bus_wdata[CMASK_MSB:CMASK_LSB];
  assign coef_write = bus_wr && hit_fctl && bus_size16 &&
                      (coef_mask == CMASK_ENABLE);                      // see R4 R3

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      iir_coef_select_r <= RST_FCTL[COEF_MSB:COEF_LSB];
    end else if (coef_write) begin
      iir_coef_select_r <= bus_wdata[COEF_MSB:COEF_LSB];                // see R4
    end
  end

  // ****************************************
  // Low-power trigger counter
  // ****************************************

  // Counts low-power ticks from zero, restarts on match
  assign trig_hit = lowpower_mode && lp_tick &&
                    (trig_count_r == lowpower_trigger_period);          // see R11

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      trig_count_r <= '0;
      acq_start    <= 1'b0;
    end else begin
      acq_start <= trig_hit;                                            // see R11
      if (!lowpower_mode || trig_hit) begin
        trig_count_r <= '0;
      end else if (lp_tick) begin
        trig_count_r <= trig_count_r + 1'b1;
      end
    end
  end

  // ****************************************
  // Current filter and wake-up requests
  // ****************************************

  // IIR on incoming current samples
  iir_lowpass u_iir (
    .mclk         (mclk),
    .rstn         (rstn),
    .coef_select  (iir_coef_select_r),
    .sample_valid (sample_valid),
    .sample_in    (sample_current),
    .filt_out     (filt_current),
    .filt_valid   (filt_valid)
  );

  // Magnitude of the filtered current against the level
  assign filt_mag     = filt_current[CUR_W-1] ? (~filt_current + 1'b1) : filt_current;
  assign current_cond = (filt_mag[CUR_W-1:CLV_LSB] > current_wake_level_r);

  // Persistence over low-power acquisitions
  persist_filter u_persist (
    .mclk   (mclk),
    .rstn   (rstn),
    .period (wake_filter_period_r),
    .cond   (current_cond),
    .step   (filt_valid && lowpower_mode),                              // see R12
    .clear  (!lowpower_mode),
    .req    (current_wake_req)
  );

  // Amp-hour count magnitude reaching a nonzero threshold
  assign ah_mag  = amp_hour_count[AH_W-1] ? (~amp_hour_count + 1'b1) : amp_hour_count;
  assign ah_cond = (amp_hour_wake_level_r != RST_AHLV) &&
                   (ah_mag >= {1'b0, amp_hour_wake_level_r});

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      amp_hour_wake_req <= 1'b0;
    end else begin
      amp_hour_wake_req <= lowpower_mode && ah_cond;
    end
  end

endmodule : lowpower_current_wakeup_regs

//--- rtl/persist_filter.sv
/*
 * Persistence filter: raises a request once a condition holds for a
 * programmed number of consecutive steps; drops it when the condition fails.
 * Assumes step and clear are one-cycle qualifiers on mclk.
 */
`timescale 1ns/1ps
module persist_filter (
  input  wire logic                           mclk,
  input  wire logic                           rstn,
  input  wire logic [lpwake_pkg::LVL_W-1:0]   period,
  input  wire logic                           cond,
  input  wire logic                           step,
  input  wire logic                           clear,
  output logic                                req
);
  import lpwake_pkg::*;

  logic [LVL_W-1:0] count_r;
  logic [LVL_W:0]   count_inc;

  assign count_inc = {1'b0, count_r} + 1'b1;

  // Count qualifying steps, saturating
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      count_r <= '0;
      req     <= 1'b0;
    end else if (clear) begin
      count_r <= '0;
      req     <= 1'b0;
    end else if (step) begin
      if (cond) begin
        count_r <= count_inc[LVL_W] ? count_r : count_inc[LVL_W-1:0];
        req     <= (count_inc >= {1'b0, period});  // see R12
      end else begin
        count_r <= '0;
        req     <= 1'b0;
      end
    end
  end

endmodule : persist_filter

//--- testbench/lpwake_chk.sv
/* Port checker for the low-power wake-up register bank.
   Assumes it is bound into the bank's top module, all on mclk. */
`timescale 1ns/1ps
module lpwake_chk (
  input  wire logic                          mclk,
  input  wire logic                          rstn,
  input  wire logic [lpwake_pkg::ADDR_W-1:0] bus_addr,
  input  wire logic                          bus_rd,
  input  wire logic                          bus_wr,
  input  wire logic                          bus_size16,
  input  wire logic [lpwake_pkg::BUS_W-1:0]  bus_rdata,
  input  wire logic                          bus_ack,
  input  wire logic                          lowpower_mode,
  input  wire logic                          lp_tick,
  input  wire logic                          sample_valid,
  input  wire logic                          acq_start,
  input  wire logic                          filt_valid,
  input  wire logic                          current_wake_req,
  input  wire logic                          amp_hour_wake_req
);
  import lpwake_pkg::*;
  // ****************************************
  // Access decode
  // ****************************************
  wire in_win = (bus_addr[15:8] == BASE_BLOCKING_HI) || (bus_addr[15:8] == BASE_NONBLOCK_HI);
  wire ctl_rd = bus_rd && in_win && (bus_addr[7:1] == OFS_FCTL[7:1]);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rstn);
  // ****************************************
  // Properties
  // ****************************************
  property p_ack; (bus_rd || bus_wr) |=> bus_ack; endproperty
  property p_no_ack; !(bus_rd || bus_wr) |=> !bus_ack; endproperty
  property p_rdata_hold; !bus_rd |=> $stable(bus_rdata); endproperty
  property p_unmapped; bus_rd && !in_win |=> bus_rdata == 16'h0000; endproperty
  property p_ctl_zero; ctl_rd |=> bus_rdata == 16'h0000; endproperty
  property p_byte_hi; bus_rd && !bus_size16 |=> bus_rdata[15:8] == 8'h00; endproperty
  property p_acq_cause; acq_start |-> $past(lowpower_mode && lp_tick); endproperty
  property p_filt; sample_valid |=> filt_valid; endproperty
  property p_filt_cause; filt_valid |-> $past(sample_valid); endproperty
  property p_wake_drop; !lowpower_mode |=> !current_wake_req && !amp_hour_wake_req; endproperty
  property p_cur_rise; $rose(current_wake_req) |-> $past(filt_valid) && lowpower_mode; endproperty
  a_ack: assert property (p_ack)
    else $error("no ack one cycle after an access");
  a_no_ack: assert property (p_no_ack)
    else $error("ack without an access");
  a_rdata_hold: assert property (p_rdata_hold)
    else $error("read data moved without a read");
  a_unmapped: assert property (p_unmapped)
    else $error("read outside both windows not zero");
  a_ctl_zero: assert property (p_ctl_zero)
    else $error("filter control read not zero");
  a_byte_hi: assert property (p_byte_hi)
    else $error("byte read upper lane not zero");
  a_acq_cause: assert property (p_acq_cause)
    else $error("acquisition start without low-power tick");
  a_filt: assert property (p_filt)
    else $error("no filter output after sample");
  a_filt_cause: assert property (p_filt_cause)
    else $error("filter output without sample");
  a_wake_drop: assert property (p_wake_drop)
    else $error("wake request outside low power");
  a_cur_rise: assert property (p_cur_rise)
    else $error("current wake request without filtered sample");
  c_acq: cover property (acq_start);
  c_cur: cover property ($rose(current_wake_req));
  c_ah: cover property ($rose(amp_hour_wake_req));
endmodule : lpwake_chk

//--- testbench/tb.sv
/* Self-checking bench for the low-power wake-up register bank.
   Assumes the bank answers every bus strobe one cycle later. */
`timescale 1ns/1ps
module tb;
  import lpwake_pkg::*;
  logic                     mclk = 1'b0;
  logic                     rstn = 1'b0;
  logic [ADDR_W-1:0]        bus_addr = 16'h0000;
  logic                     bus_rd = 1'b0, bus_wr = 1'b0, bus_size16 = 1'b1;
  logic [BUS_W-1:0]         bus_wdata = 16'h0000, bus_rdata, q;
  logic                     bus_ack, acq_start, filt_valid, current_wake_req, amp_hour_wake_req;
  logic                     lowpower_mode = 1'b0, lp_tick = 1'b0, sample_valid = 1'b0;
  logic [TRIG_W-1:0]        lowpower_trigger_period = 16'h0003;
  logic signed [CUR_W-1:0]  sample_current = 24'h000000, filt_current;
  logic signed [AH_W-1:0]   amp_hour_count = 32'h00000000;
  int                       n_fail = 0, n_tests = 0;

  lowpower_current_wakeup_regs u_lowpower_current_wakeup_regs (
    .mclk(mclk), .rstn(rstn), .bus_addr(bus_addr), .bus_rd(bus_rd), .bus_wr(bus_wr),
    .bus_size16(bus_size16), .bus_wdata(bus_wdata), .bus_rdata(bus_rdata), .bus_ack(bus_ack),
    .lowpower_mode(lowpower_mode), .lp_tick(lp_tick), .lowpower_trigger_period(lowpower_trigger_period),
    .sample_valid(sample_valid), .sample_current(sample_current), .amp_hour_count(amp_hour_count),
    .acq_start(acq_start), .filt_current(filt_current), .filt_valid(filt_valid),
    .current_wake_req(current_wake_req), .amp_hour_wake_req(amp_hour_wake_req));

  // Clock at 100 MHz
  always #5 mclk = ~mclk;

  // ****************************************
  // Shared tasks
  // ****************************************
  task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      n_fail++;
      $display("mismatch %s expected %0h seen %0h", name, exp, seen);
    end
  endtask : chk

  task automatic final_report;
    $display("checks %0d mismatches %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : final_report

  task automatic do_reset;
    rstn = 1'b0;
    repeat (3) @(negedge mclk);
    rstn = 1'b1;
  endtask : do_reset

  // One strobe cycle; ack and data taken at the next falling edge, then one idle cycle
  task automatic bus(input logic w, input logic sz, input logic [15:0] a, input logic [15:0] d);
    bus_addr = a;
    bus_wr = w;
    bus_rd = !w;
    bus_size16 = sz;
    bus_wdata = d;
    @(negedge mclk);
    bus_rd = 1'b0;
    bus_wr = 1'b0;
    q = bus_rdata;
    chk("bus_ack", bus_ack, 1);
    @(negedge mclk);
  endtask : bus

  task automatic samp(input logic [23:0] x, input logic [23:0] e);
    sample_current = x;
    sample_valid = 1'b1;
    @(negedge mclk);
    sample_valid = 1'b0;
    chk("filt_valid", filt_valid, 1);
    chk("filt_current", filt_current, e);
  endtask : samp

  // ****************************************
  // Scenarios
  // ****************************************
  task automatic t_regs;
    bus(0, 1, 16'h0E72, 0); chk("period rst", q, 16'h0000);
    bus(0, 1, 16'h0E74, 0); chk("ctl rd", q, 16'h0000);
    bus(0, 1, 16'h0E76, 0); chk("level rst", q, 16'h0000);
    bus(0, 1, 16'h0F7A, 0); chk("thr rst", q, 16'h0000);
    bus(0, 1, 16'h0F78, 0); chk("thr rst hi", q, 16'h0000);
    bus(1, 1, 16'h0F72, 16'hA500);
    bus(0, 1, 16'h0E72, 0); chk("period 16", q, 16'hA500);
    bus(0, 0, 16'h0E72, 0); chk("period 8", q, 16'h00A5);
    bus(1, 0, 16'h0E76, 16'h005A);
    bus(0, 1, 16'h0F76, 0); chk("level", q, 16'h5A00);
    bus(1, 1, 16'h0D72, 16'h1100);
    bus(0, 1, 16'h0D72, 0); chk("unmapped", q, 16'h0000);
    bus(0, 1, 16'h0E72, 0); chk("period kept", q, 16'hA500);
  endtask : t_regs

  // Hi read buffers lo; a later write must not show until the buffer is read
  task automatic t_thr;
    bus(1, 1, 16'h0F78, 16'hFFFF);
    bus(1, 1, 16'h0E7A, 16'h1234);
    bus(0, 1, 16'h0E78, 0); chk("thr hi", q, 16'h7FFF);
    bus(1, 1, 16'h0E7A, 16'h5678);
    bus(0, 1, 16'h0E7A, 0); chk("thr lo held", q, 16'h1234);
    bus(0, 1, 16'h0E7A, 0); chk("thr lo live", q, 16'h5678);
    bus(0, 0, 16'h0E78, 0); chk("thr byte 3", q, 16'h007F);
  endtask : t_thr

  task automatic t_trig;
    lowpower_mode = 1'b1;
    for (int i = 0; i < 4; i++) begin
      lp_tick = 1'b1;
      @(negedge mclk);
      lp_tick = 1'b0;
      chk("acq_start", acq_start, (i == 3));
      @(negedge mclk);
    end
    lowpower_mode = 1'b0;
    repeat (5) begin
      lp_tick = 1'b1;
      @(negedge mclk);
      chk("acq idle", acq_start, 0);
    end
    lp_tick = 1'b0;
  endtask : t_trig

  task automatic t_amp;
    bus(1, 1, 16'h0E78, 16'h0000);
    bus(1, 1, 16'h0E7A, 16'h0100);
    lowpower_mode = 1'b1;
    amp_hour_count = 32'h000000FF;
    @(negedge mclk); chk("ah below", amp_hour_wake_req, 0);
    amp_hour_count = 32'h00000100;
    @(negedge mclk); chk("ah equal", amp_hour_wake_req, 1);
    amp_hour_count = -32'sh00000100;
    @(negedge mclk); chk("ah negative", amp_hour_wake_req, 1);
    lowpower_mode = 1'b0;
    @(negedge mclk); chk("ah off", amp_hour_wake_req, 0);
  endtask : t_amp

  // Fresh accumulator per code; first output is the input times alpha
  task automatic t_iir;
    do_reset();
    bus(1, 1, 16'h0E74, 16'h0C00);
    samp(24'h100000, 24'h100000);
    for (int c = 0; c < 8; c++) begin
      do_reset();
      bus(1, 1, 16'h0F74, 16'h0E00 | 16'(c << 1));
      if (c < 5) samp(24'h100000, 24'h100000 >> (3 + c));
      else samp(24'h100000, 24'h100000);
    end
  endtask : t_iir

  task automatic t_wake;
    do_reset();
    bus(1, 1, 16'h0E72, 16'h0200);
    bus(1, 1, 16'h0E76, 16'h0500);
    lowpower_mode = 1'b1;
    samp(24'h100000, 24'h100000);
    @(negedge mclk); chk("wake first", current_wake_req, 0);
    samp(24'h100000, 24'h100000);
    @(negedge mclk); chk("wake second", current_wake_req, 1);
    samp(24'h010000, 24'h010000);
    @(negedge mclk); chk("wake low", current_wake_req, 0);
    lowpower_mode = 1'b0;
  endtask : t_wake

  initial begin
    do_reset();
    t_regs();
    t_thr();
    t_trig();
    t_amp();
    t_iir();
    t_wake();
    final_report();
  end

  // Watchdog well beyond the expected 131 cycles
  initial begin
    #200000;
    n_fail++;
    final_report();
  end
endmodule : tb

bind lowpower_current_wakeup_regs lpwake_chk u_lpwake_chk (
  .mclk(mclk), .rstn(rstn), .bus_addr(bus_addr), .bus_rd(bus_rd), .bus_wr(bus_wr),
  .bus_size16(bus_size16), .bus_rdata(bus_rdata), .bus_ack(bus_ack), .lowpower_mode(lowpower_mode),
  .lp_tick(lp_tick), .sample_valid(sample_valid), .acq_start(acq_start), .filt_valid(filt_valid),
  .current_wake_req(current_wake_req), .amp_hour_wake_req(amp_hour_wake_req));
